// File: rtl/psm_monitor.v
// per-port led stretching, negotiation status and quick-status serial stream
`timescale 1ns/1ps
`include "psm_regs.vh"
module psm_monitor #(
  parameter PORTS = 8,
  parameter LEDS = 3,
  parameter CNT_W = 25,
  parameter CYC_PER_MS = `PSM_CYC_PER_MS
) (
  input wire clk,
  input wire rst_n,
  input wire [PORTS*LEDS*4-1:0] led_func,
  input wire [PORTS*LEDS-1:0] led_event,
  input wire [PORTS-1:0] link_up,
  input wire [PORTS-1:0] activity,
  input wire [PORTS-1:0] stretch_en,
  input wire [PORTS*2-1:0] stretch_sel,
  input wire [PORTS-1:0] an_done,
  input wire [PORTS-1:0] an_restart,
  input wire [PORTS-1:0] page_rx_evt,
  input wire [PORTS-1:0] base_page_evt,
  input wire [PORTS-1:0] alt_next_page,
  input wire [PORTS-1:0] page_rx_rd,
  input wire [PORTS-1:0] base_page_rd,
  input wire [PORTS*14-1:0] quick_status,
  input wire status_shift_clock,
  output reg [PORTS*LEDS-1:0] led_out_q,
  output reg [PORTS-1:0] an_complete_q,
  output reg [PORTS-1:0] link_stat_q,
  output reg [PORTS-1:0] link_qs_q,
  output reg [PORTS-1:0] page_rx_q,
  output reg [PORTS-1:0] base_page_q,
  output reg status_serial_out
);
  localparam integer LIM30_I = `PSM_STRETCH_30_MS * CYC_PER_MS - 1;
  localparam integer LIM60_I = `PSM_STRETCH_60_MS * CYC_PER_MS - 1;
  localparam integer LIM100_I = `PSM_STRETCH_100_MS * CYC_PER_MS - 1;
  localparam [CNT_W-1:0] LIM30 = LIM30_I[CNT_W-1:0];
  localparam [CNT_W-1:0] LIM60 = LIM60_I[CNT_W-1:0];
  localparam [CNT_W-1:0] LIM100 = LIM100_I[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE_CNT = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam S_SIG = 2'b01;
  localparam S_WORD = 2'b10;

  function [CNT_W-1:0] sel_limit;
    input [1:0] sel;
    begin
      case (sel)
        `PSM_SEL_30: sel_limit = LIM30;
        `PSM_SEL_60: sel_limit = LIM60;
        default: sel_limit = LIM100;
      endcase
    end
  endfunction

  // led stretchers, one per led per port plus one activity stretcher per port
  wire [PORTS*LEDS-1:0] stretched;
  wire [PORTS-1:0] act_blink;
  genvar p, l;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      // stretched activity keeps the blink running while traffic lasts
      psm_led_stretch #(.CNT_W(CNT_W)) u_act (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(activity[p] & link_up[p]),
        .stretch_en(1'b1),
        .limit(sel_limit(stretch_sel[p*2 +: 2])),
        .led_q(act_blink[p])
      );
      for (l = 0; l < LEDS; l = l + 1) begin : g_led
        psm_led_stretch #(.CNT_W(CNT_W)) u_st (
          .clk(clk),
          .rst_n(rst_n),
          .event_in(led_event[p*LEDS+l]),
          .stretch_en(stretch_en[p]),
          .limit(sel_limit(stretch_sel[p*2 +: 2])),
          .led_q(stretched[p*LEDS+l])
        );
      end
    end
  endgenerate

  // blink phase toggles once per stretch interval while activity lasts
  reg [PORTS-1:0] blink_ph_q;
  reg [PORTS*CNT_W-1:0] blink_cnt_q;
  integer i, j;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_ph_q <= {PORTS{1'b0}};
      blink_cnt_q <= {(PORTS*CNT_W){1'b0}};
    end else begin
      for (i = 0; i < PORTS; i = i + 1) begin
        if (!link_up[i] || !act_blink[i]) begin
          blink_ph_q[i] <= 1'b0;
          blink_cnt_q[i*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
        end else if (blink_cnt_q[i*CNT_W +: CNT_W] >= sel_limit(stretch_sel[i*2 +: 2])) begin
          blink_ph_q[i] <= ~blink_ph_q[i];
          blink_cnt_q[i*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
        end else begin
          blink_cnt_q[i*CNT_W +: CNT_W] <= blink_cnt_q[i*CNT_W +: CNT_W] + ONE_CNT;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_out_q <= {(PORTS*LEDS){1'b0}};
    end else begin
      for (i = 0; i < PORTS; i = i + 1) begin
        for (j = 0; j < LEDS; j = j + 1) begin
          if (led_func[(i*LEDS+j)*4 +: 4] == `PSM_FN_LINK_ACT) begin
            // off when down, on when idle, blinking with activity
            if (!link_up[i])
              led_out_q[i*LEDS+j] <= 1'b0;
            else if (act_blink[i] || activity[i])
              led_out_q[i*LEDS+j] <= blink_ph_q[i];
            else
              led_out_q[i*LEDS+j] <= 1'b1;
          end else begin
            led_out_q[i*LEDS+j] <= stretched[i*LEDS+j];
          end
        end
      end
    end
  end

  // negotiation and link status bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      an_complete_q <= {PORTS{1'b0}};
      link_stat_q <= {PORTS{1'b0}};
      link_qs_q <= {PORTS{1'b0}};
      page_rx_q <= {PORTS{1'b0}};
      base_page_q <= {PORTS{1'b0}};
    end else begin
      for (i = 0; i < PORTS; i = i + 1) begin
        an_complete_q[i] <= an_done[i] & ~an_restart[i];
        link_stat_q[i] <= link_up[i];
        link_qs_q[i] <= link_up[i];
        // a new page wins over a read or restart clear in the same cycle
        if (page_rx_evt[i])
          page_rx_q[i] <= 1'b1;
        else if (page_rx_rd[i])
          page_rx_q[i] <= 1'b0;
        else if (alt_next_page[i] && an_restart[i])
          page_rx_q[i] <= 1'b0;
        if (base_page_evt[i])
          base_page_q[i] <= 1'b1;
        else if (base_page_rd[i])
          base_page_q[i] <= 1'b0;
      end
    end
  end

  // status shift clock synchroniser, falling edge when stages 2,3 agree low
  reg sck1_q, sck2_q, sck3_q, sck_lvl_q;
  wire sck_fall = sck_lvl_q & ~sck2_q & ~sck3_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck1_q <= 1'b0;
      sck2_q <= 1'b0;
      sck3_q <= 1'b0;
      sck_lvl_q <= 1'b0;
    end else begin
      sck1_q <= status_shift_clock;
      sck2_q <= sck1_q;
      sck3_q <= sck2_q;
      if (sck2_q == sck3_q)
        sck_lvl_q <= sck3_q;
    end
  end

  // serial stream: signature, port word, next port
  reg [1:0] st_q;
  reg [3:0] bit_q;
  reg [3:0] port_q;
  reg [`PSM_WORD_BITS-1:0] sh_q;
  wire [`PSM_WORD_BITS-1:0] word_next;
  assign word_next = {1'b0, quick_status[port_q*14 +: 14], 1'b0};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_SIG;
      bit_q <= 4'h0;
      port_q <= 4'h0;
      sh_q <= 16'h0000;
      status_serial_out <= 1'b1;
    end else if (sck_fall) begin
      case (st_q)
        S_SIG: begin
          status_serial_out <= 1'b1;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'hF) begin
            st_q <= S_WORD;
            sh_q <= word_next;
          end
        end
        S_WORD: begin
          status_serial_out <= sh_q[`PSM_QS_MSB];
          sh_q <= {sh_q[`PSM_QS_MSB-1:0], 1'b0};
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'hF) begin
            st_q <= S_SIG;
            port_q <= (port_q == PORTS-1) ? 4'h0 : port_q + 4'h1;
          end
        end
        default: st_q <= S_SIG;
      endcase
    end
  end
endmodule

// File: rtl/psm_regs.vh
// constants for the port status and led monitor block
`ifndef PSM_REGS_VH
`define PSM_REGS_VH
`define PSM_CLK_MHZ 250
`define PSM_STRETCH_30_MS 30
`define PSM_STRETCH_60_MS 60
`define PSM_STRETCH_100_MS 100
`define PSM_CYC_PER_MS (`PSM_CLK_MHZ * 1000)
`define PSM_SEL_30 2'h0
`define PSM_SEL_60 2'h1
`define PSM_SEL_100 2'h2
`define PSM_FN_LINK_ACT 4'hD
`define PSM_WORD_BITS 16
`define PSM_SIG_BITS 16
`define PSM_QS_MSB 15
`define PSM_QS_LSB 0
`endif

// File: rtl/psm_led_stretch.v
// one led pulse stretcher with edge detect and retrigger
`timescale 1ns/1ps
module psm_led_stretch #(
  parameter CNT_W = 25
) (
  input wire clk,
  input wire rst_n,
  input wire event_in,
  input wire stretch_en,
  input wire [CNT_W-1:0] limit,
  output reg led_q
);
  reg armed_prev_q;
  reg [CNT_W-1:0] cnt_q;
  reg run_q;
  wire edge_hit = event_in & ~armed_prev_q;
  wire expire = run_q && (cnt_q >= limit);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_prev_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      run_q <= 1'b0;
      led_q <= 1'b0;
    end else if (!stretch_en) begin
      // cleared so enabling with a held event starts a timer
      armed_prev_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      run_q <= 1'b0;
      led_q <= event_in;
    end else begin
      // re-arm on expiry so a held level makes a new edge
      armed_prev_q <= expire ? 1'b0 : event_in;
      if (edge_hit) begin
        cnt_q <= {CNT_W{1'b0}};
        run_q <= 1'b1;
        led_q <= 1'b1;
      end else if (expire) begin
        // a held event keeps the led lit across the re-arm
        cnt_q <= {CNT_W{1'b0}};
        run_q <= event_in;
        led_q <= event_in;
      end else if (run_q) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: testbench/psm_monitor_props.sv
// concurrent checks on the monitor's status and led ports
`timescale 1ns/1ps
module psm_monitor_props #(
  parameter PORTS = 8,
  parameter LEDS = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [PORTS*LEDS*4-1:0] led_func,
  input wire [PORTS*LEDS-1:0] led_event,
  input wire [PORTS-1:0] stretch_en,
  input wire [PORTS-1:0] link_up,
  input wire [PORTS-1:0] an_done,
  input wire [PORTS-1:0] an_restart,
  input wire [PORTS-1:0] page_rx_evt,
  input wire [PORTS-1:0] base_page_evt,
  input wire [PORTS-1:0] alt_next_page,
  input wire [PORTS-1:0] page_rx_rd,
  input wire [PORTS-1:0] base_page_rd,
  input wire [PORTS*LEDS-1:0] led_out_q,
  input wire [PORTS-1:0] an_complete_q,
  input wire [PORTS-1:0] link_stat_q,
  input wire [PORTS-1:0] link_qs_q,
  input wire [PORTS-1:0] page_rx_q,
  input wire [PORTS-1:0] base_page_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_page_set: assert property (page_rx_evt[0] |=> page_rx_q[0]) else $error("page not set");
  a_page_hold: assert property (page_rx_q[0] && !page_rx_rd[0] && !alt_next_page[0]
    |=> page_rx_q[0]) else $error("page flag lost");
  a_page_read: assert property (page_rx_rd[0] && !page_rx_evt[0] |=> !page_rx_q[0])
    else $error("page read no clear");
  a_alt_restart: assert property (alt_next_page[0] && an_restart[0] && !page_rx_evt[0]
    |=> !page_rx_q[0]) else $error("alt restart no clear");
  a_base_set: assert property (base_page_evt[0] |=> base_page_q[0]) else $error("base not set");
  a_base_read: assert property (base_page_rd[0] && !base_page_evt[0] |=> !base_page_q[0])
    else $error("base read no clear");
  a_an_complete: assert property (an_done[0] && !an_restart[0] |=> an_complete_q[0])
    else $error("an complete missing");
  a_link_both: assert property (link_up[0] |=> link_stat_q[0] && link_qs_q[0])
    else $error("link bits missing");
  a_led_dark: assert property ((led_func[3:0] == 4'hD && !link_up[0]) [*2] |-> !led_out_q[0])
    else $error("led lit link down");
  a_long_hold: assert property ((stretch_en[0] && led_event[0]
    && led_func[3:0] != 4'hD) [*2] |=> led_out_q[0]) else $error("long event led gap");
  a_stretch_off: assert property ((!stretch_en[0] && led_func[3:0] != 4'hD) [*2]
    |=> led_out_q[0] == $past(led_event[0], 2)) else $error("unstretched led wrong");
endmodule
bind psm_monitor psm_monitor_props #(.PORTS(PORTS), .LEDS(LEDS)) u_props (.clk, .rst_n,
  .led_func, .led_event, .stretch_en, .link_up, .an_done, .an_restart, .page_rx_evt,
  .base_page_evt, .alt_next_page,
  .page_rx_rd, .base_page_rd, .led_out_q, .an_complete_q, .link_stat_q, .link_qs_q,
  .page_rx_q, .base_page_q);

// File: testbench/psm_qs_sink.sv
// far side model: makes shift clock, samples serial stream
`timescale 1ns/1ps
module psm_qs_sink (
  input wire en,
  input wire status_serial_out,
  output reg status_shift_clock,
  output reg [63:0] bits_q
);
  initial status_shift_clock = 1'b1;
  initial bits_q = 64'h0;
  always begin
    #62.5;
    if (en) status_shift_clock = ~status_shift_clock;
  end
  always @(posedge status_shift_clock) bits_q <= {bits_q[62:0], status_serial_out};
endmodule

// File: testbench/tb.sv
// self-checking bench for the port monitor
`timescale 1ns/1ps
module tb;
  reg clk = 0, rst_n = 0, sck_en = 0;
  reg [7:0] led_func = 0;
  reg [3:0] stretch_sel = 0;
  reg [27:0] quick_status = 28'h9A5C3E1;
  reg [1:0] led_event = 0, link_up = 0, activity = 0, stretch_en = 0, an_done = 0;
  reg [1:0] an_restart = 0, page_rx_evt = 0, base_page_evt = 0, alt_next_page = 0;
  reg [1:0] page_rx_rd = 0, base_page_rd = 0;
  wire [1:0] led_out_q, an_complete_q, link_stat_q, link_qs_q, page_rx_q, base_page_q;
  wire status_serial_out, status_shift_clock;
  wire [63:0] bits_q;
  wire [63:0] stream_exp = {16'hFFFF, 1'b0, quick_status[13:0], 1'b0,
    16'hFFFF, 1'b0, quick_status[27:14], 1'b0};
  integer failures = 0, n_tests = 0, s, n;
  psm_monitor #(.PORTS(2), .LEDS(1), .CYC_PER_MS(10)) uut (.clk, .rst_n, .led_func,
    .led_event, .link_up, .activity, .stretch_en, .stretch_sel, .an_done, .an_restart,
    .page_rx_evt, .base_page_evt, .alt_next_page, .page_rx_rd, .base_page_rd,
    .quick_status, .status_shift_clock, .led_out_q, .an_complete_q, .link_stat_q,
    .link_qs_q, .page_rx_q, .base_page_q, .status_serial_out);
  psm_qs_sink u_sink (.en(sck_en), .status_serial_out, .status_shift_clock, .bits_q);
  initial forever #2 clk = ~clk;
  task cyc(input integer k); begin
    repeat (k) @(posedge clk);
    #1;
  end endtask
  task chk(input [63:0] g, input [63:0] e); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("BAD %0t got %0h want %0h", $time, g, e);
    end
  end endtask
  task report_and_stop; begin
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  task t_stream; begin
    sck_en = 1;
    repeat (64) @(posedge status_shift_clock);
    sck_en = 0;
    cyc(1);
    chk(bits_q, stream_exp);
    $display("stream test done");
  end endtask
  task t_pages; begin
    page_rx_evt = 1;
    cyc(1);
    page_rx_evt = 0;
    an_restart = 1;
    cyc(1);
    an_restart = 0;
    cyc(3);
    chk(page_rx_q, 2'h1);
    page_rx_rd = 1;
    page_rx_evt = 1;
    cyc(1);
    page_rx_rd = 0;
    page_rx_evt = 0;
    cyc(1);
    chk(page_rx_q, 2'h1);
    page_rx_rd = 1;
    cyc(1);
    page_rx_rd = 0;
    cyc(1);
    chk(page_rx_q, 2'h0);
    alt_next_page = 1;
    page_rx_evt = 1;
    cyc(1);
    page_rx_evt = 0;
    an_restart = 1;
    cyc(1);
    an_restart = 0;
    cyc(1);
    chk(page_rx_q, 2'h0);
    base_page_evt = 1;
    cyc(1);
    base_page_evt = 0;
    cyc(3);
    chk(base_page_q, 2'h1);
    base_page_rd = 1;
    cyc(1);
    base_page_rd = 0;
    cyc(1);
    chk(base_page_q, 2'h0);
    link_up = 1;
    an_done = 1;
    cyc(2);
    chk({an_complete_q, link_stat_q, link_qs_q}, 6'h15);
    $display("status test done");
  end endtask
  task t_stretch; begin
    stretch_en = 1;
    for (s = 0; s < 4; s = s + 1) begin
      stretch_sel = s[3:0];
      led_event = 1;
      cyc(1);
      led_event = 0;
      cyc((s < 2) ? 300 * (s + 1) - 50 : 950);
      chk(led_out_q, 2'h1);
      cyc(100);
      chk(led_out_q, 2'h0);
    end
    stretch_sel = 0;
    led_event = 1;
    cyc(1);
    led_event = 0;
    cyc(150);
    led_event = 1;
    cyc(1);
    led_event = 0;
    cyc(250);
    chk(led_out_q, 2'h1);
    cyc(100);
    chk(led_out_q, 2'h0);
    led_event = 1;
    cyc(2);
    n = 0;
    repeat (648) begin
      if (led_out_q[0] !== 1'b1) n = n + 1;
      cyc(1);
    end
    chk(n, 0);
    chk(led_out_q, 2'h1);
    stretch_en = 0;
    cyc(2);
    chk(led_out_q, 2'h1);
    led_event = 0;
    cyc(2);
    chk(led_out_q, 2'h0);
    $display("stretch test done");
  end endtask
  task t_link_act; begin
    led_func = 8'h0D;
    stretch_en = 1;
    link_up = 0;
    cyc(3);
    chk(led_out_q, 2'h0);
    link_up = 1;
    cyc(3);
    chk(led_out_q, 2'h1);
    activity = 1;
    n = 0;
    repeat (1500) begin
      s = led_out_q[0];
      cyc(1);
      if (led_out_q[0] !== s[0]) n = n + 1;
    end
    chk(n, 5);
    activity = 0;
    cyc(700);
    chk(led_out_q, 2'h1);
    $display("link activity test done");
  end endtask
  initial begin
    #200000;
    failures = failures + 1;
    report_and_stop;
  end
  initial begin
    cyc(5);
    rst_n = 1;
    cyc(1);
    t_stream;
    t_pages;
    t_stretch;
    t_link_act;
    report_and_stop;
  end
endmodule
